// ==== hw/i2c_read_master.sv ====
// I2C bus master: full read transaction and scripted address phase.
// Host side on clock; bus engine on bit_clk, which must run freely.
// Pins are open-drain: the board supplies the pull-ups.

// Functional notes
// - Ack every read byte except the last
// - Wait for idle bus, fail after one second
// - Read using 7-bit or 10-bit addressing
// - Lost arbitration ends read with error
// - Unacknowledged read address reports error
// - Clean read ends with a stop condition
// - Return exactly the requested bytes, in order
// - Address byte: address high, direction bit 0
// - Scripted addressed read sets direction one
// - Sample ninth clock for address acknowledge
// - Scripted address nack stops with error
// - Execute commands in order, report outcome
// - Scripted addressed write sets direction zero
module i2c_read_master
    import i2c_rd_pkg::*;
#(
    parameter int unsigned BUS_FREE_TIMEOUT = i2c_rd_pkg::BUS_FREE_TIMEOUT_CYC
) (
    // System clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // Bus engine clock
    input  wire logic                     bit_clk,
    // Command port
    input  wire logic                     cmd_valid,
    input  wire i2c_rd_pkg::cmd_t         cmd,
    output logic                          cmd_ready,
    // Completion
    output i2c_rd_pkg::result_t           result,
    // Read data stream
    output logic                          rd_valid,
    output logic [i2c_rd_pkg::DATA_W-1:0] rd_data,
    input  wire logic                     rd_ready,
    // Bus pins
    input  wire logic                     scl_in,
    output logic                          scl_out,
    output logic                          scl_oe_n,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_n
);
    import i2c_rd_pkg::*;

    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(BUS_FREE_TIMEOUT - 1);

    // System domain
    sys_state_t          sst;
    cmd_t                cmd_hold;
    logic                cmd_tgl;
    logic [TMO_W-1:0]    tmo;
    logic                bus_busy;
    logic                scl_m1, scl_m2;
    logic                sda_m1, sda_m2, sda_m3;
    logic                done_s1, done_s2, done_seen;
    logic                byte_s1, byte_s2, byte_seen;
    logic                fifo_ready;

    // Link domain
    link_state_t         lst;
    cmd_t                lcmd;
    status_t             lstatus;
    logic [2:0]          ph;
    logic [3:0]          bit_idx;
    logic [7:0]          shreg;
    logic [7:0]          remaining;
    logic                addr_acked;
    logic                done_tgl;
    logic                byte_tgl;
    logic [DATA_W-1:0]   byte_data;
    logic                cmd_seen;
    logic                rst_l1, link_rst;
    logic                cmd_s1, cmd_s2;
    logic                ack_s1, ack_s2;
    logic                sda_l1, sda_l2;

    // Open-drain: only ever pull low, the enables carry the data
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // ----
    // System domain: synchronisers
    // ----

    // Pins and link toggles, two flops each before use
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {scl_m2, scl_m1}         <= 2'h3;
            {sda_m3, sda_m2, sda_m1} <= 3'h7;
            {done_s2, done_s1}       <= 2'h0;
            {byte_s2, byte_s1}       <= 2'h0;
        end else begin
            {scl_m2, scl_m1}         <= {scl_m1, scl_in};
            {sda_m3, sda_m2, sda_m1} <= {sda_m2, sda_m1, sda_in};
            {done_s2, done_s1}       <= {done_s1, done_tgl};
            {byte_s2, byte_s1}       <= {byte_s1, byte_tgl};
        end
    end

    // Bus monitor: start marks busy, stop marks free (any master)
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_busy <= 1'b0;
        end else if (scl_m2 && sda_m3 && !sda_m2) begin
            bus_busy <= 1'b1;
        end else if (scl_m2 && !sda_m3 && sda_m2) begin
            bus_busy <= 1'b0;
        end
    end

    // ----
    // System domain: command sequencer
    // ----

    // cmd_hold stays stable until the link reports, so the link may
    // read it as a whole word after the toggle arrives.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sst       <= SY_IDLE;
            cmd_ready <= 1'b1;
            cmd_hold  <= '0;
            cmd_tgl   <= 1'b0;
            tmo       <= '0;
            result    <= '0;
            done_seen <= 1'b0;
        end else begin
            result.done <= 1'b0;
            unique case (sst)
                SY_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_hold <= cmd;
                        tmo      <= '0;
                        if (cmd.port != PORT_ONLY) begin
                            result <= '{done: 1'b1, status: ST_BAD_PORT};
                        end else begin
                            cmd_ready <= 1'b0;
                            if (cmd.op == OP_READ) begin
                                sst <= SY_WAIT_FREE;
                            end else begin
                                // Scripted address relies on an earlier start
                                cmd_tgl <= ~cmd_tgl;
                                sst     <= SY_RUN;
                            end
                        end
                    end
                end
                SY_WAIT_FREE: begin
                    if (!bus_busy) begin
                        cmd_tgl <= ~cmd_tgl;
                        sst     <= SY_RUN;
                    end else if (tmo == TMO_LAST) begin
                        result    <= '{done: 1'b1, status: ST_BUS_TIMEOUT};
                        cmd_ready <= 1'b1;
                        sst       <= SY_IDLE;
                    end else begin
                        tmo <= tmo + 1'b1;
                    end
                end
                SY_RUN: begin
                    if (done_s2 != done_seen) begin
                        done_seen <= done_s2;
                        result    <= '{done: 1'b1, status: lstatus};
                        cmd_ready <= 1'b1;
                        sst       <= SY_IDLE;
                    end
                end
            endcase
        end
    end

    // ----
    // System domain: read bytes into the FIFO
    // ----

    // A byte is pending while the toggles differ; the echo back to
    // the link is held off while the FIFO is full, stalling the bus.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            byte_seen <= 1'b0;
        end else if (byte_s2 != byte_seen && fifo_ready) begin
            byte_seen <= byte_s2;
        end
    end

    byte_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (byte_s2 != byte_seen),
        .in_data   (byte_data),
        .in_ready  (fifo_ready),
        .out_valid (rd_valid),
        .out_data  (rd_data),
        .out_ready (rd_ready)
    );

    // ----
    // Link domain: synchronisers
    // ----

    // Reset is carried across too, so the engine leaves reset cleanly
    always_ff @(posedge bit_clk) begin
        {link_rst, rst_l1} <= {rst_l1, sys_rst};
    end

    always_ff @(posedge bit_clk) begin
        if (link_rst) begin
            {cmd_s2, cmd_s1} <= 2'h0;
            {ack_s2, ack_s1} <= 2'h0;
            {sda_l2, sda_l1} <= 2'h3;
        end else begin
            {cmd_s2, cmd_s1} <= {cmd_s1, cmd_tgl};
            {ack_s2, ack_s1} <= {ack_s1, byte_seen};
            {sda_l2, sda_l1} <= {sda_l1, sda_in};
        end
    end

    // ----
    // Link domain: bus engine
    // ----

    // Eight phases per bit: drive SDA with SCL low, raise SCL, sample
    // late in the high time (after the two-flop lag), then drop SCL.
    // Clock stretching by slaves is not honoured.
    always_ff @(posedge bit_clk) begin
        if (link_rst) begin
            lst        <= L_IDLE;
            ph         <= '0;
            bit_idx    <= '0;
            shreg      <= '0;
            remaining  <= '0;
            addr_acked <= 1'b0;
            lcmd       <= '0;
            lstatus    <= ST_OK;
            done_tgl   <= 1'b0;
            byte_tgl   <= 1'b0;
            byte_data  <= '0;
            cmd_seen   <= 1'b0;
            scl_oe_n   <= 1'b1;
            sda_oe_n   <= 1'b1;
        end else begin
            if (lst == L_IDLE || lst == L_HANDOFF || lst == L_REPORT) begin
                ph <= '0;
            end else begin
                ph <= ph + 3'h1;
            end
            unique case (lst)
                L_IDLE: begin
                    if (cmd_s2 != cmd_seen) begin
                        cmd_seen  <= cmd_s2;
                        lcmd      <= cmd_hold;
                        lstatus   <= ST_OK;
                        remaining <= cmd_hold.requested_byte_count;
                        bit_idx   <= '0;
                        if (cmd_hold.op == OP_READ) begin
                            lst <= L_START;
                            if (cmd_hold.ten_bit) begin
                                shreg <= ten_hdr(cmd_hold.addr[9:8], DIR_WRITE);
                            end else begin
                                shreg <= addr_byte(cmd_hold.addr[6:0], DIR_READ);
                            end
                        end else if (cmd_hold.op == OP_SCRIPT_ADDR_READ) begin
                            lst   <= L_ADDR1;
                            shreg <= addr_byte(cmd_hold.addr[6:0], DIR_READ);
                        end else begin
                            lst   <= L_ADDR1;
                            shreg <= addr_byte(cmd_hold.addr[6:0], DIR_WRITE);
                        end
                    end
                end

                // Start and repeated start share one waveform
                L_START, L_RSTART: begin
                    if (ph == PH_SETUP) begin
                        sda_oe_n <= 1'b1;
                    end
                    if (ph == PH_RISE) begin
                        scl_oe_n <= 1'b1;
                    end
                    if (ph == PH_MID) begin
                        sda_oe_n <= 1'b0;
                    end
                    if (ph == PH_FALL) begin
                        scl_oe_n <= 1'b0;
                        lst      <= (lst == L_START) ? L_ADDR1 : L_ADDR3;
                    end
                end

                // Nine-clock byte slot, address or read
                L_ADDR1, L_ADDR2, L_ADDR3, L_READ: begin
                    if (ph == PH_SETUP) begin
                        scl_oe_n <= 1'b0;
                        if (lst == L_READ) begin
                            sda_oe_n <= !(bit_idx == ACK_SLOT && remaining > 8'h01);
                        end else begin
                            sda_oe_n <= !(bit_idx != ACK_SLOT && !shreg[7]);
                        end
                    end
                    if (ph == PH_RISE) begin
                        scl_oe_n <= 1'b1;
                    end
                    if (ph == PH_SAMPLE) begin
                        if (lst == L_READ) begin
                            if (bit_idx != ACK_SLOT) begin
                                shreg <= {shreg[6:0], sda_l2};
                            end
                        end else if (bit_idx == ACK_SLOT) begin
                            addr_acked <= !sda_l2;
                        end else if (sda_oe_n && !sda_l2) begin
                            // Released a one but the wire is low: another master won
                            lstatus  <= ST_ARB_LOST;
                            scl_oe_n <= 1'b1;
                            sda_oe_n <= 1'b1;
                            lst      <= L_REPORT;
                        end
                    end
                    if (ph == PH_FALL) begin
                        scl_oe_n <= 1'b0;
                        if (bit_idx != ACK_SLOT) begin
                            bit_idx <= bit_idx + 4'h1;
                            if (lst != L_READ) begin
                                shreg <= {shreg[6:0], 1'b0};
                            end
                        end else begin
                            bit_idx <= '0;
                            if (lst == L_READ) begin
                                byte_data <= shreg;
                                byte_tgl  <= ~byte_tgl;
                                remaining <= remaining - 8'h01;
                                lst       <= L_HANDOFF;
                            end else if (!addr_acked) begin
                                lstatus <= ST_ADDR_NACK;
                                lst     <= L_STOP;
                            end else if (lst == L_ADDR1 && lcmd.op != OP_READ) begin
                                // Scripted address holds SCL low for the next command
                                lst <= L_REPORT;
                            end else if (lst == L_ADDR1 && lcmd.ten_bit) begin
                                shreg <= lcmd.addr[7:0];
                                lst   <= L_ADDR2;
                            end else if (lst == L_ADDR2) begin
                                shreg <= ten_hdr(lcmd.addr[9:8], DIR_READ);
                                lst   <= L_RSTART;
                            end else begin
                                lst <= (remaining == 8'h00) ? L_STOP : L_READ;
                            end
                        end
                    end
                end

                // Wait for the host side to take the byte; SCL stays low
                L_HANDOFF: begin
                    if (ack_s2 == byte_tgl) begin
                        lst <= (remaining == 8'h00) ? L_STOP : L_READ;
                    end
                end

                L_STOP: begin
                    if (ph == PH_SETUP) begin
                        sda_oe_n <= 1'b0;
                    end
                    if (ph == PH_RISE) begin
                        scl_oe_n <= 1'b1;
                    end
                    if (ph == PH_MID) begin
                        sda_oe_n <= 1'b1;
                    end
                    if (ph == PH_FALL) begin
                        lst <= L_REPORT;
                    end
                end

                // Status is stable before the toggle leaves the domain
                L_REPORT: begin
                    done_tgl <= ~done_tgl;
                    lst      <= L_IDLE;
                end
            endcase
        end
    end

endmodule : i2c_read_master

// ==== include/i2c_rd_pkg.sv ====
// Shared constants, types and helpers for the I2C read master.
// Assumes a 125 MHz system clock and a separate bit clock for the bus engine.
package i2c_rd_pkg;

    // ----
    // Timing
    // ----
    localparam int unsigned CLOCK_HZ             = 125_000_000;
    localparam int unsigned BUS_FREE_TIMEOUT_S   = 1;
    localparam int unsigned BUS_FREE_TIMEOUT_CYC = BUS_FREE_TIMEOUT_S * CLOCK_HZ;
    localparam int          TMO_W                = 27;

    // Bit slot phases on the bit clock (eight per SCL period)
    localparam logic [2:0]  PH_SETUP  = 3'h0;
    localparam logic [2:0]  PH_RISE   = 3'h2;
    localparam logic [2:0]  PH_MID    = 3'h4;
    localparam logic [2:0]  PH_SAMPLE = 3'h5;
    localparam logic [2:0]  PH_FALL   = 3'h7;
    localparam logic [3:0]  ACK_SLOT  = 4'h8;

    // ----
    // Sizes and encodings
    // ----
    localparam int          DATA_W       = 8;
    localparam int          FIFO_DEPTH   = 8;
    localparam logic [1:0]  PORT_ONLY    = 2'h0;
    localparam logic [4:0]  TEN_BIT_MARK = 5'h1E;
    localparam logic        DIR_READ     = 1'b1;
    localparam logic        DIR_WRITE    = 1'b0;

    typedef enum logic [1:0] {
        OP_READ,
        OP_SCRIPT_ADDR_READ,
        OP_SCRIPT_ADDR_WRITE
    } op_t;

    typedef enum logic [2:0] {
        ST_OK,
        ST_BUS_TIMEOUT,
        ST_ARB_LOST,
        ST_ADDR_NACK,
        ST_BAD_PORT
    } status_t;

    typedef enum {SY_IDLE, SY_WAIT_FREE, SY_RUN} sys_state_t;

    typedef enum {
        L_IDLE, L_START, L_ADDR1, L_ADDR2, L_RSTART,
        L_ADDR3, L_READ, L_HANDOFF, L_STOP, L_REPORT
    } link_state_t;

    typedef struct packed {
        op_t        op;
        logic       ten_bit;
        logic [9:0] addr;
        logic [7:0] requested_byte_count;
        logic [1:0] port;
    } cmd_t;

    typedef struct packed {
        logic    done;
        status_t status;
    } result_t;

    // ----
    // Address byte builders
    // ----
    function automatic logic [7:0] addr_byte(input logic [6:0] a7, input logic dir);
        addr_byte = {a7, dir};
    endfunction : addr_byte

    function automatic logic [7:0] ten_hdr(input logic [1:0] hi, input logic dir);
        ten_hdr = {TEN_BIT_MARK, hi, dir};
    endfunction : ten_hdr

endpackage : i2c_rd_pkg

// ==== hw/byte_fifo.sv ====
// Small shifting FIFO with valid/ready on both sides.
// Single clock domain; head word and flags come straight from flops.
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic [CW-1:0]    wr_idx;
    logic             push;
    logic             pop;

    // ----
    // Occupancy
    // ----
    assign push   = in_valid && in_ready;
    assign pop    = out_valid && out_ready;
    assign wr_idx = pop ? count - CW'(1) : count;

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    // Flags registered so the drain side sees clean levels
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count     <= '0;
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
        end else begin
            count     <= next_count;
            out_valid <= next_count != '0;
            in_ready  <= next_count != CW'(DEPTH);
        end
    end

    // ----
    // Storage: head at index 0, shifts down on pop
    // ----
    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        localparam int NX = (i + 1 < DEPTH) ? i + 1 : i;
        always_ff @(posedge clock) begin
            if (push && wr_idx == CW'(i)) begin
                mem[i] <= in_data;
            end else if (pop) begin
                mem[i] <= mem[NX];
            end
        end
    end

    assign out_data = mem[0];

endmodule : byte_fifo

// ==== tb/i2c_rd_chk.sv ====
// Port checker for the read master.
// Assumes the command, result and read ports of the package types.
module i2c_rd_chk
    import i2c_rd_pkg::*;
(
    // Clock and reset
    input wire logic                clock,
    input wire logic                sys_rst,
    // Host side
    input wire logic                cmd_valid,
    input wire i2c_rd_pkg::cmd_t    cmd,
    input wire logic                cmd_ready,
    input wire i2c_rd_pkg::result_t result,
    input wire logic                rd_valid,
    input wire logic [DATA_W-1:0]   rd_data,
    input wire logic                rd_ready,
    // Bus enables
    input wire logic                scl_oe_n,
    input wire logic                sda_oe_n
);
    // All checks live on the host clock
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    ready_drop_a: assert property (
        cmd_valid && cmd_ready && cmd.port == PORT_ONLY |=> !cmd_ready) else $error("busy not shown");
    bad_port_a: assert property (
        cmd_valid && cmd_ready && cmd.port != PORT_ONLY |=> result.done && result.status == ST_BAD_PORT)
        else $error("bad port not refused");
    done_pulse_a: assert property (result.done |=> !result.done) else $error("done too long");
    ready_back_a: assert property (result.done |=> cmd_ready) else $error("ready not back");
    ready_cause_a: assert property (
        $rose(cmd_ready) |-> result.done || $past(result.done)) else $error("ready without done");
    status_hold_a: assert property (!result.done |-> $stable(result.status)) else $error("status moved");
    rd_hold_a: assert property (
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data)) else $error("read data lost");
    release_a: assert property (
        result.done && result.status != ST_OK |-> scl_oe_n && sda_oe_n) else $error("bus held on error");
endmodule : i2c_rd_chk

bind i2c_read_master i2c_rd_chk chk (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .result(result), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));

// ==== tb/i2c_slave_model.sv ====
// Behavioural I2C slave and rival agent on the resolved wires.
// Assumes pull-ups on both lines; a pull output of 1 holds a line low.
module i2c_slave_model (
    // Resolved wires
    input  wire logic       scl,
    input  wire logic       sda,
    // Scenario controls
    input  wire logic       ack_en,
    input  wire logic       arb,
    input  wire logic [7:0] seed,
    // Open-drain pulls
    output logic            scl_pull,
    output logic            sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh, dat, got[$];
    logic       tx = 0, go = 0, sp = 0, acks[$];
    int         bitn = 0, nb = 0, stops = 0;
    always @(posedge sda) if (scl) stops++; // Stop seen on the wires
    initial scl_pull = 0;
    assign sda_pull = sp | arb; // Rival master drags data low
    // Start or repeated start reframes the bytes
    always @(negedge sda) if (scl) begin
        bitn = 0;
        nb = 0;
        tx = 0;
        go = 0;
        dat = seed;
    end
    // Sample on the rising clock; a high ack ends our transmit
    always @(posedge scl) begin
        if (bitn == 8) begin
            if (tx) begin
                acks.push_back(sda);
                dat++;
                tx = !sda;
            end
            bitn = 0;
        end else begin
            sh = {sh[6:0], sda};
            bitn++;
        end
    end
    // Drive on the falling clock: ack a received byte or shift out data
    always @(negedge scl) begin
        if (bitn == 8 && !tx) begin
            got.push_back(sh);
            go = sh[0] && nb == 0; // Only a header byte turns the bus round
            nb++;
            sp = ack_en;
        end else begin
            if (bitn == 0 && go) begin
                tx = 1;
                go = 0;
            end
            sp = tx && bitn < 8 && !dat[7 - bitn];
        end
    end
    // Start (0) or stop (1) made by another party; the start precedes script addressing
    task automatic cond(input logic stop);
        scl_pull = stop;
        #1000 sp = 1;
        #1000 scl_pull = !stop;
        #1000 sp = 0;
        if (!stop) #1000 scl_pull = 0; // Data released while clock low: no stop
        #1000 bitn = 0;
    endtask : cond
endmodule : i2c_slave_model

// ==== tb/testbench.sv ====
// Self-checking bench for the read master with a slave model.
// Assumes package, design, checker and slave model are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_rd_pkg::*;
    logic       clock = 0, bit_clk = 0, sys_rst = 1, cmd_valid = 0, rd_ready = 0, ack_en = 1, arb = 0, arm = 0;
    logic       cmd_ready, rd_valid, scl_oe_n, sda_oe_n, scl_pull, sda_pull;
    logic [7:0] rd_data, seed = 0, rnd = 8'h2F, rx[$];
    cmd_t       cmd = '0;
    result_t    result;
    int         failures = 0, compares = 0, stall = 0;
    wire logic  scl = scl_oe_n & ~scl_pull; // Pull-up wins unless someone drives low
    wire logic  sda = sda_oe_n & ~sda_pull;
    i2c_read_master #(.BUS_FREE_TIMEOUT(200)) uut (.clock(clock), .sys_rst(sys_rst), .bit_clk(bit_clk),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .result(result), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_ready(rd_ready), .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n));
    i2c_slave_model peer (.scl(scl), .sda(sda), .ack_en(ack_en), .arb(arb), .seed(seed),
        .scl_pull(scl_pull), .sda_pull(sda_pull));
    // Clocks; the bit clock is free running with an unrelated phase
    always #4 clock = ~clock;
    initial #17 forever #62.5 bit_clk = ~bit_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Random drain stalls; a long stall fills the FIFO
    always @(posedge clock) begin
        rnd <= lfsr(rnd);
        rd_ready <= rnd[0] && stall == 0;
        if (stall > 0) stall <= stall - 1;
        if (rd_valid && rd_ready) rx.push_back(rd_data);
    end
    always @(negedge scl_oe_n) if (arm) arb <= 1'b1; // Rival grabs data after our start
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // One command, checked against the slave model
    task automatic run(input op_t op, input logic ten, input logic [9:0] a, input logic [7:0] n,
                       input logic [1:0] p, input status_t es);
        int k, s;
        k = 0;
        s = peer.stops;
        rx.delete();
        peer.got.delete();
        peer.acks.delete();
        @(posedge clock);
        seed <= rnd;
        cmd_valid <= 1'b1;
        cmd <= '{op, ten, a, n, p};
        @(posedge clock);
        cmd_valid <= 1'b0;
        do @(negedge clock); while (result.done !== 1'b1 && ++k < 40000);
        check(8'(result.status), 8'(es));
        repeat (300) @(negedge clock);
        if (es == ST_OK || es == ST_ADDR_NACK) begin
            if (!ten) check(peer.got[0], {a[6:0], op != OP_SCRIPT_ADDR_WRITE});
            else begin
                check(peer.got[0], {5'h1E, a[9:8], 1'b0});
                check(peer.got[1], a[7:0]);
                check(peer.got[2], {5'h1E, a[9:8], 1'b1});
            end
        end
        if (es == ST_OK && op == OP_READ) begin
            check(8'(rx.size()), n);
            check(8'(peer.acks.size()), n);
            check(8'(peer.stops - s), 8'h01);
            foreach (rx[i]) check(rx[i], 8'(seed + i));
            foreach (peer.acks[i]) check(8'(peer.acks[i]), 8'(i == n - 1));
        end
        $display("test op %0d status %0d done", op, es);
    endtask : run
    initial begin
        repeat (20) @(posedge clock);
        repeat (4) @(posedge bit_clk);
        @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge bit_clk);
        for (int n = 1; n < 4; n++) run(OP_READ, 1'b0, {3'h0, rnd[6:0]}, 8'(n), PORT_ONLY, ST_OK);
        stall <= 12000;
        run(OP_READ, 1'b0, 10'h055, 8'h0C, PORT_ONLY, ST_OK);
        run(OP_READ, 1'b1, {rnd[1:0], rnd}, 8'h03, PORT_ONLY, ST_OK);
        for (int p = 1; p < 4; p++) run(OP_READ, 1'b0, 10'h011, 8'h01, 2'(p), ST_BAD_PORT);
        peer.cond(1'b0);
        run(OP_READ, 1'b0, 10'h022, 8'h01, PORT_ONLY, ST_BUS_TIMEOUT);
        peer.cond(1'b1);
        arm = 1;
        run(OP_READ, 1'b0, 10'h07F, 8'h02, PORT_ONLY, ST_ARB_LOST);
        arm = 0;
        arb <= 1'b0;
        repeat (300) @(negedge clock);
        ack_en = 0;
        run(OP_READ, 1'b0, 10'h03C, 8'h02, PORT_ONLY, ST_ADDR_NACK);
        peer.cond(1'b0);
        run(OP_SCRIPT_ADDR_WRITE, 1'b0, {3'h0, rnd[6:0]}, 8'h00, PORT_ONLY, ST_ADDR_NACK);
        ack_en = 1;
        peer.cond(1'b0);
        run(OP_SCRIPT_ADDR_READ, 1'b0, {3'h0, rnd[6:0]}, 8'h00, PORT_ONLY, ST_OK);
        conclude();
    end
    // Watchdog well past the expected run length
    initial begin
        #800000;
        failures++;
        conclude();
    end
endmodule : testbench
